// *** logic/cpc_map.svh ***
// Register offsets, reset values, field positions and timing for the charger option bank
`ifndef CPC_MAP_SVH
`define CPC_MAP_SVH

`define CPC_OFF_OPT3_LOW       8'h34
`define CPC_OFF_OPT3_HIGH      8'h35
`define CPC_OFF_HOT_LOW        8'h36
`define CPC_OFF_HOT_HIGH       8'h37

`define CPC_RST_OPT3_LOW       8'h34
`define CPC_RST_OPT3_HIGH      8'h04
`define CPC_RST_HOT_MULTI      16'h4a81
`define CPC_RST_HOT_SINGLE     16'h4a09

// Low byte of option three
`define CPC_FORCE_OFF_BIT      7
`define CPC_BUS_VAP_BIT        6
`define CPC_PIN_ROLE_BIT       5
`define CPC_CLAMP_MSB          4
`define CPC_CLAMP_LSB          3
`define CPC_COMPARATOR_ENABLE_BIT         2
`define CPC_OFF_IN_HIZ_BIT     1
`define CPC_PWR_MON_BIT        0
// High byte of option three
`define CPC_HIZ_BIT            7
`define CPC_OTG_EN_BIT         4
`define CPC_BIGCAP_BIT         0
// Hot option, 16-bit view
`define CPC_SECOND_CURRENT_LIMIT_LEVEL_MSB          15
`define CPC_SECOND_CURRENT_LIMIT_LEVEL_LSB          11
`define CPC_CRIT_DEG_MSB       10
`define CPC_CRIT_DEG_LSB       9
`define CPC_LOW_PCT_BIT        8
`define CPC_VSYS_MSB           7
`define CPC_VSYS_LSB           2
`define CPC_LOW_TRIP_EN_BIT    0

`define CPC_SECOND_CURRENT_LIMIT_LEVEL_IGNORED      5'h1f
`define CPC_SECOND_CURRENT_LIMIT_LEVEL_STEP_LAST    5'h19

// Timing
`define CPC_CLK_NS             10
`define CPC_VSYS_DEG_NS        5000
`define CPC_CRIT_DEG0_NS       15000
`define CPC_CRIT_DEG1_NS       100000
`define CPC_CRIT_DEG2_NS       400000
`define CPC_CRIT_DEG3_NS       800000

`endif

// *** logic/cpc_pkg.sv ***
// Types shared by the charger option bank
package cpc_pkg;

  typedef enum logic [3:0] {
    CPC_IDLE, CPC_ADDR, CPC_ACK_ADDR, CPC_REG, CPC_ACK_REG,
    CPC_WDATA, CPC_ACK_W, CPC_RDATA, CPC_RACK
  } cpc_state_t;

  typedef struct packed {
    logic       large_cap_comp_enable;
    logic       battery_switch_off;
    logic       bus_vap_active;
    logic       otg_mode;
    logic       vap_pin_mode;
    logic       clamp_enable;
    logic [4:0] inductor_avg_clamp_amps;
    logic       comparator_enable;
    logic       power_monitor_mode;
    logic       low_quiescent;
    logic       regulator_on;
    logic [5:0] sys_voltage_code;
    logic       bus_discharge_trigger;
    logic [8:0] second_current_limit_pct;
    logic       second_current_limit_event;
    logic       processor_hot_alert;
    logic [6:0] regulation_trip_pct;
  } cpc_ctrl_t;

endpackage

// *** logic/cpc_top.sv ***
// Charger option and processor-hot configuration bank with its two-wire register port
//
// Contract
// - Big-capacitance bit set enables OTG loop compensation; clear disables it.
// - Writing 1 to force-off outside battery-only mode is refused; bit stays 0.
// - During battery-only OTG operation the force-off bit is held at 0.
// - In battery-only mode force-off at 1 turns battery switch off; resets to 0.
// - Bus-side assist for modes 2 and 3 only when its enable bit is 1; resets off.
// - Pin-role 1 (reset) makes mode pin control OTG; 0 makes it control assist.
// - Clamp field: 00 six amps, 01 ten, 10 fifteen (reset), 11 disabled.
// - Comparator enable bit, reset 1, turns the active-low comparator on.
// - In high-impedance mode switch stays on at 0 (reset), turns off at 1.
// - In OTG, power monitor reports discharge minus OTG at 0, discharge only at 1.
// - Bus discharge triggers when system voltage stays below threshold for 5 us; the logic does this only in pin assist mode.
// - Threshold equals 3.2 V plus 100 mV per code step, up to 9.5 V.
// - Single-cell uses only low three code bits, capping at 3.9 V.
// - Power-on threshold code 000010 single-cell, 100000 for two to four cells.
// - Limit code 1..25 gives 110..230% by 5%; 26..30 gives 250..450% by 50%.
// - Limit code 11111 is ignored on write; field resets to 01001 (150%).
// - Flag event when input current exceeds limit; critical level is 110% of it.
// - Critical deglitch before alert: 15, 100 (reset), 400 or 800 microseconds.
// - Lower trip select bit: 0 gives 83% (reset), 1 gives 91%.
// - Hot option resets to 0x4a81 multi-cell, 0x4a09 single-cell.
// - Lower-trip enable 0 follows regulation setting; 1 uses lower percentage.
// - OTG mode only when OTG enable bit set and mode pin high.
// - High-impedance mode lowers quiescent current; regulator stays on above lockout.
`include "cpc_map.svh"

module cpc_top
  import cpc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR     = 7'h55,
  parameter int         CRIT_DEG1_CYC = `CPC_CRIT_DEG1_NS / `CPC_CLK_NS,
  parameter int         CRIT_DEG2_CYC = `CPC_CRIT_DEG2_NS / `CPC_CLK_NS,
  parameter int         CRIT_DEG3_CYC = `CPC_CRIT_DEG3_NS / `CPC_CLK_NS
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        single_cell,
  input  wire logic        battery_only,
  input  wire logic        battery_otg,
  input  wire logic        external_mode_pin,
  input  wire logic        bus_above_uvlo,
  input  wire logic        sys_below_threshold,
  input  wire logic [15:0] input_current_ma,
  input  wire logic [15:0] input_current_limit_ma,
  output cpc_ctrl_t        ctrl
);

  localparam int VSYS_DEG_CYC  = `CPC_VSYS_DEG_NS / `CPC_CLK_NS;
  localparam int CRIT_DEG0_CYC = `CPC_CRIT_DEG0_NS / `CPC_CLK_NS;

  // Two-wire slave
  cpc_state_t  state_q;
  logic        scl_q;
  logic        sda_q;
  logic [7:0]  shift_q;
  logic [3:0]  cnt_q;
  logic [7:0]  ptr_q;
  logic        rw_q;
  logic        more_q;
  logic        oe_q;
  logic        sda_o_q;

  logic [7:0]  opt3_low_q;
  logic [7:0]  opt3_high_q;
  logic [15:0] hot_q;

  wire scl_rise = scl_i & ~scl_q;
  wire scl_fall = ~scl_i & scl_q;
  wire start_c  = scl_i & scl_q & sda_q & ~sda_i;
  wire stop_c   = scl_i & scl_q & ~sda_q & sda_i;
  wire byte_end = scl_fall & (cnt_q == 4'h8);
  wire addr_hit = (shift_q[7:1] == DEV_ADDR);
  wire wr_en    = byte_end & (state_q == CPC_WDATA);

  wire sel_low   = (ptr_q == `CPC_OFF_OPT3_LOW);
  wire sel_high  = (ptr_q == `CPC_OFF_OPT3_HIGH);
  wire sel_hot_l = (ptr_q == `CPC_OFF_HOT_LOW);
  wire sel_hot_h = (ptr_q == `CPC_OFF_HOT_HIGH);
  wire [7:0] rd_byte = sel_low   ? opt3_low_q  :
                       sel_high  ? opt3_high_q :
                       sel_hot_l ? hot_q[7:0]  :
                       sel_hot_h ? hot_q[15:8] : 8'h00;

  always_ff @(posedge clk) begin
    scl_q <= srst ? 1'b1 : scl_i;
    sda_q <= srst ? 1'b1 : sda_i;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= CPC_IDLE;
      shift_q <= 8'h00;
      cnt_q   <= 4'h0;
      ptr_q   <= 8'h00;
      rw_q    <= 1'b0;
      more_q  <= 1'b0;
      oe_q    <= 1'b0;
      sda_o_q <= 1'b0;
    end else if (start_c) begin
      state_q <= CPC_ADDR;
      cnt_q   <= 4'h0;
      oe_q    <= 1'b0;
    end else if (stop_c) begin
      state_q <= CPC_IDLE;
      oe_q    <= 1'b0;
    end else begin
      case (state_q)
        CPC_ADDR, CPC_REG, CPC_WDATA: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_i};
            cnt_q   <= cnt_q + 4'h1;
          end else if (byte_end) begin
            cnt_q <= 4'h0;
            if (state_q == CPC_ADDR) begin
              rw_q    <= shift_q[0];
              oe_q    <= addr_hit;
              state_q <= addr_hit ? CPC_ACK_ADDR : CPC_IDLE;
            end else if (state_q == CPC_REG) begin
              ptr_q   <= shift_q;
              oe_q    <= 1'b1;
              state_q <= CPC_ACK_REG;
            end else begin
              ptr_q   <= ptr_q + 8'h01;
              oe_q    <= 1'b1;
              state_q <= CPC_ACK_W;
            end
          end
        end
        CPC_ACK_ADDR: begin
          if (scl_fall) begin
            if (rw_q) begin
              oe_q    <= ~rd_byte[7];
              shift_q <= {rd_byte[6:0], 1'b0};
              cnt_q   <= 4'h1;
              state_q <= CPC_RDATA;
            end else begin
              oe_q    <= 1'b0;
              state_q <= CPC_REG;
            end
          end
        end
        CPC_ACK_REG, CPC_ACK_W: begin
          if (scl_fall) begin
            oe_q    <= 1'b0;
            state_q <= CPC_WDATA;
          end
        end
        CPC_RDATA: begin
          if (scl_fall) begin
            if (cnt_q == 4'h8) begin
              oe_q    <= 1'b0;
              ptr_q   <= ptr_q + 8'h01;
              state_q <= CPC_RACK;
            end else begin
              oe_q    <= ~shift_q[7];
              shift_q <= {shift_q[6:0], 1'b0};
              cnt_q   <= cnt_q + 4'h1;
            end
          end
        end
        CPC_RACK: begin
          if (scl_rise) begin
            more_q <= ~sda_i;
          end else if (scl_fall) begin
            if (more_q) begin
              oe_q    <= ~rd_byte[7];
              shift_q <= {rd_byte[6:0], 1'b0};
              cnt_q   <= 4'h1;
              state_q <= CPC_RDATA;
            end else begin
              state_q <= CPC_IDLE;
            end
          end
        end
        default: begin
          state_q <= CPC_IDLE;
        end
      endcase
    end
  end

  // Register bank next values
  wire       otg_en     = opt3_high_q[`CPC_OTG_EN_BIT];
  wire [7:0] low_wr     = {shift_q[7] & battery_only, shift_q[6:0]};
  wire [7:0] low_sel    = (wr_en & sel_low) ? low_wr : opt3_low_q;
  wire [7:0] opt3_low_d = {low_sel[7] & ~battery_otg, low_sel[6:0]};
  wire [7:0] opt3_high_d = (wr_en & sel_high) ? shift_q : opt3_high_q;
  wire [4:0] ilim_wr    = (shift_q[7:3] == `CPC_SECOND_CURRENT_LIMIT_LEVEL_IGNORED) ?
                          hot_q[`CPC_SECOND_CURRENT_LIMIT_LEVEL_MSB:`CPC_SECOND_CURRENT_LIMIT_LEVEL_LSB] : shift_q[7:3];
  wire [15:0] hot_d     = (wr_en & sel_hot_h) ? {ilim_wr, shift_q[2:0], hot_q[7:0]} :
                          (wr_en & sel_hot_l) ? {hot_q[15:8], shift_q} : hot_q;
  wire [15:0] hot_rst   = single_cell ? `CPC_RST_HOT_SINGLE : `CPC_RST_HOT_MULTI;

  always_ff @(posedge clk) begin
    opt3_low_q  <= srst ? `CPC_RST_OPT3_LOW : opt3_low_d;
    opt3_high_q <= srst ? `CPC_RST_OPT3_HIGH : opt3_high_d;
    hot_q       <= srst ? hot_rst : hot_d;
  end

  // Functional decode
  wire       hiz_mode = opt3_high_q[`CPC_HIZ_BIT];
  wire       pin_otg  = opt3_low_q[`CPC_PIN_ROLE_BIT];
  wire [1:0] clamp    = opt3_low_q[`CPC_CLAMP_MSB:`CPC_CLAMP_LSB];
  wire [5:0] vsys_raw = hot_q[`CPC_VSYS_MSB:`CPC_VSYS_LSB];
  wire [5:0] vsys_eff = single_cell ? {3'b000, vsys_raw[2:0]} : vsys_raw;
  wire [4:0] ilim     = hot_q[`CPC_SECOND_CURRENT_LIMIT_LEVEL_MSB:`CPC_SECOND_CURRENT_LIMIT_LEVEL_LSB];
  wire [1:0] deg_sel  = hot_q[`CPC_CRIT_DEG_MSB:`CPC_CRIT_DEG_LSB];
  wire       vap_pin  = ~pin_otg & external_mode_pin;
  wire [8:0] ilim_pct = (ilim <= `CPC_SECOND_CURRENT_LIMIT_LEVEL_STEP_LAST) ?
                        9'(105 + 5 * int'(ilim)) :
                        9'(250 + 50 * (int'(ilim) - 26));
  wire [4:0] clamp_amps = (clamp == 2'b00) ? 5'h06 :
                          (clamp == 2'b01) ? 5'h0a :
                          (clamp == 2'b10) ? 5'h0f : 5'h00;
  wire [6:0] trip_pct = ~hot_q[`CPC_LOW_TRIP_EN_BIT] ? 7'h64 :
                        hot_q[`CPC_LOW_PCT_BIT] ? 7'h5b : 7'h53;
  wire [31:0] lim_thr  = 32'(input_current_limit_ma) * 32'(ilim_pct) / 32'd100;
  wire [31:0] crit_thr = lim_thr * 32'd11 / 32'd10;
  wire        over_lim = 32'(input_current_ma) > lim_thr;
  wire        over_crit = 32'(input_current_ma) > crit_thr;
  wire [31:0] deg_cyc = (deg_sel == 2'b00) ? 32'(CRIT_DEG0_CYC) :
                        (deg_sel == 2'b01) ? 32'(CRIT_DEG1_CYC) :
                        (deg_sel == 2'b10) ? 32'(CRIT_DEG2_CYC) : 32'(CRIT_DEG3_CYC);

  // Deglitch counters
  logic [31:0] vsys_cnt_q;
  logic [31:0] crit_cnt_q;
  wire vsys_cnt_done = (vsys_cnt_q >= 32'(VSYS_DEG_CYC));
  wire crit_cnt_done = (crit_cnt_q >= deg_cyc);
  wire [31:0] vsys_cnt_d = ~sys_below_threshold ? 32'h0 :
                           vsys_cnt_done ? vsys_cnt_q : vsys_cnt_q + 32'h1;
  wire [31:0] crit_cnt_d = ~over_crit ? 32'h0 :
                           crit_cnt_done ? crit_cnt_q : crit_cnt_q + 32'h1;

  always_ff @(posedge clk) begin
    vsys_cnt_q <= srst ? 32'h0 : vsys_cnt_d;
    crit_cnt_q <= srst ? 32'h0 : crit_cnt_d;
  end

  cpc_ctrl_t ctrl_d;
  always_comb begin
    ctrl_d = '0;
    ctrl_d.large_cap_comp_enable   = opt3_high_q[`CPC_BIGCAP_BIT];
    ctrl_d.battery_switch_off      = (battery_only & opt3_low_q[`CPC_FORCE_OFF_BIT]) |
                                     (hiz_mode & opt3_low_q[`CPC_OFF_IN_HIZ_BIT]);
    ctrl_d.bus_vap_active          = vap_pin & opt3_low_q[`CPC_BUS_VAP_BIT];
    ctrl_d.otg_mode                = pin_otg & otg_en & external_mode_pin;
    ctrl_d.vap_pin_mode            = vap_pin;
    ctrl_d.clamp_enable            = (clamp != 2'b11);
    ctrl_d.inductor_avg_clamp_amps = clamp_amps;
    ctrl_d.comparator_enable       = opt3_low_q[`CPC_COMPARATOR_ENABLE_BIT];
    ctrl_d.power_monitor_mode      = opt3_low_q[`CPC_PWR_MON_BIT];
    ctrl_d.low_quiescent           = hiz_mode;
    ctrl_d.regulator_on            = ~hiz_mode | bus_above_uvlo;
    ctrl_d.sys_voltage_code        = vsys_eff;
    ctrl_d.bus_discharge_trigger   = vap_pin & vsys_cnt_done;
    ctrl_d.second_current_limit_pct   = ilim_pct;
    ctrl_d.second_current_limit_event = over_lim;
    ctrl_d.processor_hot_alert     = crit_cnt_done;
    ctrl_d.regulation_trip_pct     = trip_pct;
  end

  always_ff @(posedge clk) begin
    ctrl <= srst ? '0 : ctrl_d;
  end

  assign sda_oe = oe_q;
  assign sda_o  = sda_o_q;

endmodule

// *** bench/cpc_top_sva.sv ***
// Port assertions for the charger option bank
module cpc_top_sva
  import cpc_pkg::*;
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  input wire logic        single_cell,
  input wire logic        battery_only,
  input wire logic        battery_otg,
  input wire logic        external_mode_pin,
  input wire logic        bus_above_uvlo,
  input wire logic        sys_below_threshold,
  input wire logic [15:0] input_current_ma,
  input wire logic [15:0] input_current_limit_ma,
  input wire cpc_ctrl_t   ctrl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] low_q;

  always_ff @(posedge clk) begin
    if (srst || !sys_below_threshold) begin
      low_q <= 10'h000;
    end else if (low_q != 10'h3ff) begin
      low_q <= low_q + 10'h001;
    end
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (srst);

  a_otg_needs_pin: assert property (ctrl.otg_mode |-> $past(external_mode_pin))
    else $error("otg mode without mode pin");
  a_vap_role_pin: assert property (
    ctrl.bus_vap_active |-> ctrl.vap_pin_mode && !ctrl.otg_mode)
    else $error("bus assist outside pin assist role");
  a_hiz_regulator: assert property (
    ctrl.low_quiescent |-> ctrl.regulator_on == $past(bus_above_uvlo))
    else $error("regulator state wrong in hiz");
  a_clamp_codes: assert property (
    ctrl.clamp_enable |-> ctrl.inductor_avg_clamp_amps inside {5'h06, 5'h0a, 5'h0f})
    else $error("clamp amps not a legal value");
  a_single_cap: assert property (
    single_cell && $past(single_cell) |-> ctrl.sys_voltage_code[5:3] == 3'h0)
    else $error("single cell threshold not capped");
  a_discharge_early: assert property ($rose(ctrl.bus_discharge_trigger) |-> low_q >= 10'd497)
    else $error("discharge before deglitch");
  a_discharge_late: assert property (
    low_q >= 10'd505 && ctrl.vap_pin_mode |-> ##[0:2] ctrl.bus_discharge_trigger)
    else $error("discharge missing after deglitch");
  a_force_off_cause: assert property (
    ctrl.battery_switch_off |-> $past(battery_only) || ctrl.low_quiescent)
    else $error("switch off without cause");
  a_trip_values: assert property (
    !$past(srst) |-> ctrl.regulation_trip_pct inside {7'h64, 7'h53, 7'h5b})
    else $error("trip percent not legal");
  a_sda_open_drain: assert property (sda_oe |-> !sda_o)
    else $error("data line driven high");

  c_otg: cover property (ctrl.otg_mode);
  c_discharge: cover property (ctrl.bus_discharge_trigger);
  c_hot: cover property (ctrl.processor_hot_alert);
endmodule

bind cpc_top cpc_top_sva u_sva (.clk(clk), .srst(srst), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .single_cell(single_cell), .battery_only(battery_only),
  .battery_otg(battery_otg), .external_mode_pin(external_mode_pin),
  .bus_above_uvlo(bus_above_uvlo), .sys_below_threshold(sys_below_threshold),
  .input_current_ma(input_current_ma), .input_current_limit_ma(input_current_limit_ma),
  .ctrl(ctrl));

// *** bench/cpc_host_model.sv ***
// Two-wire host model: open-drain master with register write and read
module cpc_host_model #(
  parameter logic [6:0] ADDR = 7'h55
) (
  input  wire logic clk,
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic sc(input logic c, input logic d);
    scl = c;
    sda_low = !d;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic start();
    sc(1'b1, 1'b0);
    sc(1'b0, 1'b0);
  endtask
  task automatic stop();
    sc(1'b0, 1'b0);
    sc(1'b1, 1'b0);
    sc(1'b1, 1'b1);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sc(1'b0, b);
    sc(1'b1, b);
    r = sda;
    sc(1'b1, b);
    sc(1'b0, b);
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r);
    logic k;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(a, k);
  endtask
  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    logic [7:0] r;
    start();
    xfer({ADDR, 1'b0}, 1'b1, r);
    xfer(off, 1'b1, r);
    xfer(d, 1'b1, r);
    stop();
  endtask
  task automatic rd(input logic [7:0] off, output logic [7:0] d);
    logic [7:0] r;
    start();
    xfer({ADDR, 1'b0}, 1'b1, r);
    xfer(off, 1'b1, r);
    sc(1'b0, 1'b1);
    sc(1'b1, 1'b1);
    start();
    xfer({ADDR, 1'b1}, 1'b1, r);
    xfer(8'hff, 1'b1, d);
    stop();
  endtask
endmodule

// *** bench/tb_top.sv ***
// Self-checking bench for the charger option and processor-hot bank
module tb_top;
  import cpc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        scl;
  logic        host_low;
  wire         sda;
  logic        dut_o;
  logic        dut_oe;
  logic        single_cell = 1'b0;
  logic        bat_only = 1'b0;
  logic        bat_otg = 1'b0;
  logic        mode_pin = 1'b0;
  logic        uvlo = 1'b1;
  logic        sys_below = 1'b0;
  logic [15:0] i_ma = 16'h0000;
  logic [15:0] lim_ma = 16'h0000;
  cpc_ctrl_t   ctrl;
  int          bad_count = 0;
  int          n_checks = 0;
  logic [7:0]  rv;
  logic [23:0] rows [5] = '{24'h350101, 24'h34ff7f, 24'h37ff4f, 24'h360505, 24'h38aa00};
  logic [4:0]  amps [4] = '{5'h06, 5'h0a, 5'h0f, 5'h00};
  logic [4:0]  codes [4] = '{5'h01, 5'h19, 5'h1a, 5'h1e};
  logic [8:0]  pcts [4] = '{9'h06e, 9'h0e6, 9'h0fa, 9'h1c2};

  always #5 clk = ~clk;
  assign sda = !(host_low || (dut_oe && !dut_o));

  cpc_host_model host (.clk(clk), .scl(scl), .sda_low(host_low), .sda(sda));
  cpc_top #(.CRIT_DEG1_CYC(20), .CRIT_DEG2_CYC(40), .CRIT_DEG3_CYC(80)) dut (
    .clk(clk), .srst(srst), .scl_i(scl), .sda_i(sda), .sda_o(dut_o), .sda_oe(dut_oe),
    .single_cell(single_cell), .battery_only(bat_only), .battery_otg(bat_otg),
    .external_mode_pin(mode_pin), .bus_above_uvlo(uvlo), .sys_below_threshold(sys_below),
    .input_current_ma(i_ma), .input_current_limit_ma(lim_ma), .ctrl(ctrl));

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_ctl(input string n, input logic [8:0] e, input logic [8:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdx(input logic [7:0] off, input logic [7:0] e);
    host.rd(off, rv);
    chk_reg($sformatf("reg %h", off), e, rv);
  endtask
  task automatic rst_dut(input logic one_cell);
    srst = 1'b1;
    step(1);
    single_cell = one_cell;
    step(19);
    srst = 1'b0;
    step(1);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    summarize();
  end

  initial begin
    rst_dut(1'b0);
    step(2);
    chk_ctl("clamp", 9'h00f, 9'(ctrl.inductor_avg_clamp_amps));
    chk_ctl("cmp", 9'h001, 9'(ctrl.comparator_enable));
    chk_ctl("vsys", 9'h020, 9'(ctrl.sys_voltage_code));
    chk_ctl("pct", 9'h096, ctrl.second_current_limit_pct);
    chk_ctl("trip", 9'h053, 9'(ctrl.regulation_trip_pct));
    rdx(8'h34, 8'h34);
    rdx(8'h35, 8'h04);
    rdx(8'h36, 8'h81);
    rdx(8'h37, 8'h4a);
    foreach (rows[k]) begin
      host.wr(rows[k][23:16], rows[k][15:8]);
      rdx(rows[k][23:16], rows[k][7:0]);
    end
    chk_ctl("bigcap", 9'h001, 9'(ctrl.large_cap_comp_enable));
    for (int k = 0; k < 4; k++) begin
      host.wr(8'h34, 8'h24 | {3'h0, k[1:0], 3'h0});
      step(2);
      chk_ctl("clamp", 9'(amps[k]), 9'(ctrl.inductor_avg_clamp_amps));
      chk_ctl("clampen", 9'(k != 3), 9'(ctrl.clamp_enable));
    end
    for (int k = 0; k < 4; k++) begin
      host.wr(8'h37, {codes[k], 3'h2});
      step(2);
      chk_ctl("pct", pcts[k], ctrl.second_current_limit_pct);
    end
    host.wr(8'h37, 8'h4b);
    step(2);
    chk_ctl("trip", 9'h05b, 9'(ctrl.regulation_trip_pct));
    host.wr(8'h36, 8'h04);
    step(2);
    chk_ctl("trip", 9'h064, 9'(ctrl.regulation_trip_pct));
    mode_pin = 1'b1;
    host.wr(8'h35, 8'h11);
    step(2);
    chk_ctl("otg", 9'h001, 9'(ctrl.otg_mode));
    mode_pin = 1'b0;
    step(2);
    chk_ctl("otg", 9'h000, 9'(ctrl.otg_mode));
    host.wr(8'h34, 8'h44);
    mode_pin = 1'b1;
    step(2);
    chk_ctl("vap", 9'h003, {7'h0, ctrl.vap_pin_mode, ctrl.bus_vap_active});
    sys_below = 1'b1;
    step(400);
    chk_ctl("disch", 9'h000, 9'(ctrl.bus_discharge_trigger));
    step(150);
    chk_ctl("disch", 9'h001, 9'(ctrl.bus_discharge_trigger));
    sys_below = 1'b0;
    mode_pin = 1'b0;
    lim_ma = 16'h03e8;
    i_ma = 16'h0640;
    step(40);
    chk_ctl("event", 9'h001, 9'(ctrl.second_current_limit_event));
    chk_ctl("hot", 9'h000, 9'(ctrl.processor_hot_alert));
    i_ma = 16'h07d0;
    step(10);
    chk_ctl("hot", 9'h000, 9'(ctrl.processor_hot_alert));
    step(15);
    chk_ctl("hot", 9'h001, 9'(ctrl.processor_hot_alert));
    i_ma = 16'h0000;
    bat_only = 1'b1;
    host.wr(8'h34, 8'ha4);
    rdx(8'h34, 8'ha4);
    chk_ctl("swoff", 9'h001, 9'(ctrl.battery_switch_off));
    bat_otg = 1'b1;
    step(2);
    rdx(8'h34, 8'h24);
    bat_otg = 1'b0;
    bat_only = 1'b0;
    host.wr(8'h34, 8'h27);
    host.wr(8'h35, 8'h80);
    step(2);
    chk_ctl("hiz", 9'h007, {6'h0, ctrl.battery_switch_off, ctrl.low_quiescent,
                            ctrl.power_monitor_mode});
    chk_ctl("bigcap", 9'h000, 9'(ctrl.large_cap_comp_enable));
    uvlo = 1'b0;
    step(2);
    chk_ctl("ldo", 9'h000, 9'(ctrl.regulator_on));
    uvlo = 1'b1;
    rst_dut(1'b1);
    rdx(8'h36, 8'h09);
    host.wr(8'h36, 8'hfc);
    step(2);
    chk_ctl("vsys", 9'h007, 9'(ctrl.sys_voltage_code));
    summarize();
  end
endmodule
